/* File: sim/fskws_host.sv */
`timescale 1ns/10ps
module fskws_host (
  // Clock and test controls
  input wire logic aclk,
  input wire logic mode,
  input wire logic clr,
  input wire logic [3:0] n_pulse,
  // Resolved pin levels
  input wire logic sbc_o,
  input wire logic data_out,
  input wire logic word_ready_n,
  output logic sbc_i,
  // Collected results
  output logic [7:0] got,
  output logic [3:0] edges,
  output logic rdy_after
);
  logic last = 1'b1;
  logic [7:0] got0, got1;
  assign got = mode ? got1 : got0;
  // Mode 0: plain shift register on the device strobe
  always @(posedge aclk) begin
    last <= sbc_o;
    if (clr) begin
      got0 <= 8'h00;
      edges <= 4'h0;
    end else if (!mode && sbc_o && !last) begin
      got0 <= {data_out, got0[7:1]};
      edges <= edges + 4'h1;
    end
  end
  // Mode 1: own 80 ns clock, still between words, every edge 3 ns after an aclk rising edge
  initial begin
    sbc_i = 1'b0;
    forever begin
      @(negedge word_ready_n);
      if (mode) begin
        #13;
        for (int i = 0; i < n_pulse; i++) begin
          sbc_i = 1'b1;
          #40;
          sbc_i = 1'b0;
          #35;
          if (i == 0) rdy_after <= word_ready_n;
          if (i < 8) got1 <= {data_out, got1[7:1]};
          #5;
        end
      end
    end
  end
endmodule // fskws_host

/* File: sim/fskws_top_assertions.sv */
`timescale 1ns/10ps
module fskws_top_assertions #(
  parameter int HALF_CYCLES = 40,
  parameter int HOLD_CYCLES = 400,
  parameter int QUAL_CYCLES = 100
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Line levels
  input wire logic fsk_bit,
  input wire logic band_active,
  // Three-wire pins
  input wire logic data_out,
  input wire logic serial_bit_clock_o,
  input wire logic serial_bit_clock_oe,
  input wire logic word_ready_n_o,
  input wire logic word_ready_n_oe,
  input wire logic carrier_present_n_o,
  input wire logic carrier_present_n_oe
);
  logic [19:0] band_q, idle_q, rdy_q;
  logic car, rdy;
  assign car = carrier_present_n_oe && !carrier_present_n_o;
  assign rdy = word_ready_n_oe && !word_ready_n_o;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Raw band run lengths, saturated so they never wrap; the word-ready run length is not saturated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      band_q <= 20'h0;
      idle_q <= 20'h0;
      rdy_q <= 20'h0;
    end else begin
      band_q <= band_active ? band_q + 20'(band_q < QUAL_CYCLES) : 20'h0;
      idle_q <= band_active ? 20'h0 : idle_q + 20'(idle_q < HOLD_CYCLES);
      rdy_q <= rdy ? rdy_q + 20'h1 : 20'h0;
    end
  end
  a_push_pull: assert property (
    !serial_bit_clock_oe && !$past(serial_bit_clock_oe)
    |-> word_ready_n_oe && carrier_present_n_oe)
    else $error("mode 1 pin not driven");
  a_open_drain: assert property (
    serial_bit_clock_oe && $past(serial_bit_clock_oe)
    |-> (!word_ready_n_oe || !word_ready_n_o)
    && (!carrier_present_n_oe || !carrier_present_n_o))
    else $error("open drain drives high");
  a_rdy_width: assert property (rdy |-> rdy_q < HALF_CYCLES)
    else $error("word ready too long");
  a_rdy_full: assert property (
    $fell(rdy) && serial_bit_clock_oe && car |-> rdy_q == HALF_CYCLES)
    else $error("word ready width");
  a_clk_car: assert property (
    serial_bit_clock_oe && !serial_bit_clock_o |-> car)
    else $error("strobe without carrier");
  a_idle_high: assert property (
    serial_bit_clock_oe && $past(serial_bit_clock_oe) && !car
    && !$past(car) |-> data_out)
    else $error("data not idle high");
  a_car_qual: assert property ($rose(car) |-> band_q >= QUAL_CYCLES)
    else $error("carrier too early");
  a_car_hold: assert property (
    $fell(car) && !band_active |-> idle_q >= HOLD_CYCLES)
    else $error("carrier released early");
  a_data_follow: assert property (
    serial_bit_clock_oe && $past(serial_bit_clock_oe, 3) && car
    && $past(car, 4) && $past(fsk_bit, 2) == $past(fsk_bit, 4)
    |-> data_out == $past(fsk_bit, 3))
    else $error("data not following line");
  a_clk_low: assert property (
    $fell(serial_bit_clock_o) && serial_bit_clock_oe
    |-> !serial_bit_clock_o [*8])
    else $error("strobe low too short");
endmodule // fskws_top_assertions
bind fskws_top fskws_top_assertions #(
  .HALF_CYCLES(HALF_CYCLES),
  .HOLD_CYCLES(HOLD_CYCLES),
  .QUAL_CYCLES(QUAL_CYCLES)
) u_fskws_top_assertions (
  .aclk, .aresetn, .fsk_bit, .band_active, .data_out,
  .serial_bit_clock_o, .serial_bit_clock_oe,
  .word_ready_n_o, .word_ready_n_oe,
  .carrier_present_n_o, .carrier_present_n_oe
);

/* File: sim/fskws_top_tb.sv */
`timescale 1ns/10ps
module fskws_top_tb;
  import fskws_pkg::*;
  localparam int BITC = 80;
  logic aclk, aresetn, ce, fsk_bit, band_active, mode, clr, rdy_after;
  logic s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid;
  logic s_axil_rready, s_axil_awready, s_axil_wready, s_axil_bvalid;
  logic s_axil_arready, s_axil_rvalid, data_out;
  logic [ADDR_W-1:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb, n_pulse, edges;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic serial_bit_clock_i, serial_bit_clock_o, serial_bit_clock_oe;
  logic word_ready_n_o, word_ready_n_oe;
  logic carrier_present_n_o, carrier_present_n_oe;
  logic [7:0] got;
  int n_mismatch, tests_run;
  // Pull-ups on the open-drain lines
  wire logic wr_n = word_ready_n_oe ? word_ready_n_o : 1'b1;
  wire logic cd_n = carrier_present_n_oe ? carrier_present_n_o : 1'b1;
  fskws_top #(.BIT_CYCLES(80), .HALF_CYCLES(40), .HOLD_CYCLES(400),
    .QUAL_CYCLES(100)) u_fskws_top (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
    .fsk_bit(fsk_bit), .band_active(band_active),
    .serial_bit_clock_i(serial_bit_clock_i),
    .serial_bit_clock_o(serial_bit_clock_o),
    .serial_bit_clock_oe(serial_bit_clock_oe), .data_out(data_out),
    .word_ready_n_o(word_ready_n_o), .word_ready_n_oe(word_ready_n_oe),
    .carrier_present_n_o(carrier_present_n_o),
    .carrier_present_n_oe(carrier_present_n_oe));
  fskws_host u_fskws_host (.aclk(aclk), .mode(mode), .clr(clr),
    .n_pulse(n_pulse), .sbc_o(serial_bit_clock_o), .data_out(data_out),
    .word_ready_n(wr_n), .sbc_i(serial_bit_clock_i), .got(got),
    .edges(edges), .rdy_after(rdy_after));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
      if (s_axil_bvalid) break;
    end
    s_axil_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axil_bresp});
  endtask
  task automatic rchk(input string n, input logic [ADDR_W-1:0] a,
    input logic [31:0] m, e, input logic [1:0] r);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
      if (s_axil_rvalid) break;
    end
    s_axil_rready <= 1'b0;
    chk(n, e, s_axil_rdata & m);
    chk({n, " resp"}, {30'h0, r}, {30'h0, s_axil_rresp});
  endtask
  // Start bit, eight data bits LSB first, stop bit, then idle mark
  task automatic send(input logic [7:0] b);
    fsk_bit <= 1'b0;
    tick(BITC);
    for (int i = 0; i < 8; i++) begin
      fsk_bit <= b[i];
      tick(BITC);
    end
    fsk_bit <= 1'b1;
    tick(3 * BITC);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {aresetn, band_active, mode, clr, s_axil_awvalid} = 5'h2;
    {s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = 4'h0;
    {ce, fsk_bit} = 2'h3;
    s_axil_awaddr = REG_CTRL;
    s_axil_araddr = REG_CTRL;
    s_axil_wdata = 32'h0;
    s_axil_wstrb = 4'hf;
    n_pulse = 4'ha;
    tick(16);
    aresetn <= 1'b1;
    clr <= 1'b0;
    rchk("ctrl", REG_CTRL, 32'h3, 32'h0, RESP_OKAY);
    rchk("unmapped", 4'hc, 32'hffffffff, 32'h0, RESP_SLVERR);
    wr(4'hc, 32'h3, RESP_SLVERR);
    rchk("ctrl kept", REG_CTRL, 32'h3, 32'h0, RESP_OKAY);
    send(8'h55);
    rchk("words", REG_WORDS, 32'hffff, 32'h0, RESP_OKAY);
    chk("strobes", 32'h0, {28'h0, edges});
    $display("test idle done");
    band_active <= 1'b1;
    tick(60);
    chk("cd early", 32'h1, {31'h0, cd_n});
    tick(60);
    chk("cd on", 32'h0, {31'h0, cd_n});
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    send(8'ha5);
    chk("m0 byte", 32'ha5, {24'h0, got});
    chk("m0 strobes", 32'h8, {28'h0, edges});
    rchk("byte", REG_STATUS, 32'hff00, 32'ha500, RESP_OKAY);
    rchk("words", REG_WORDS, 32'hffff, 32'h1, RESP_OKAY);
    chk("m0 rdy oe", 32'h0, {31'h0, word_ready_n_oe});
    $display("test mode 0 done");
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    mode <= 1'b1;
    send(8'h3c);
    chk("m1 byte", 32'h3c, {24'h0, got});
    chk("m1 clear", 32'h1, {31'h0, rdy_after});
    rchk("left", REG_STATUS, 32'hf0, 32'h0, RESP_OKAY);
    chk("m1 oe", 32'h0, {31'h0, serial_bit_clock_oe});
    chk("m1 rdy oe", 32'h1, {31'h0, word_ready_n_oe});
    $display("test mode 1 done");
    band_active <= 1'b0;
    tick(200);
    chk("cd hold", 32'h0, {31'h0, cd_n});
    tick(300);
    chk("cd off", 32'h1, {31'h0, cd_n});
    band_active <= 1'b1;
    tick(150);
    // A space on the line would show on the data pin unless powered down
    fsk_bit <= 1'b0;
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    tick(4);
    chk("pd cd", 32'h1, {31'h0, cd_n});
    chk("pd data", 32'h1, {31'h0, data_out});
    fsk_bit <= 1'b1;
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    $display("test carrier done");
    end_sim;
  end
  // Whole sequence needs about 3700 cycles
  initial begin
    tick(20000);
    n_mismatch++;
    end_sim;
  end
endmodule // fskws_top_tb

/* File: verilog/fskws_pkg.sv */
package fskws_pkg;
  // System clock and link rate
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD = 1200;
  // Bit period rounds down to whole cycles
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int HALF_CYC = BIT_CYC / 2;
  // Carrier release hysteresis and qualification, in milliseconds
  localparam int HOLD_MS = 10;
  localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int QUAL_MS = 3;
  localparam int QUAL_CYC = QUAL_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 20;
  localparam int DATA_BITS = 8;
  localparam int IDX_W = 4;
  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_WORDS = 4'h8;
  // Control fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_POWER_DOWN_REQUEST_BIT = 1;
  localparam logic CTRL_MODE_RST = 1'h0;
  localparam logic CTRL_POWER_DOWN_REQUEST_RST = 1'h0;
  // Status fields
  localparam int STAT_CAR_BIT = 0;
  localparam int STAT_RDY_BIT = 1;
  localparam int STAT_LEFT_LSB = 4;
  localparam int STAT_BYTE_LSB = 8;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } fskws_rx_type;
endpackage

/* File: verilog/fskws_sync.sv */
`timescale 1ns/10ps
module fskws_sync
  import fskws_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fskws_sync_type;

  fskws_sync_type s_q, s_d;

  initial begin
    if (W < 1) $error("fskws_sync: W must be at least 1");
  end

  always_comb begin
    s_d = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;
endmodule // fskws_sync

/* File: verilog/fskws_top.sv */
`timescale 1ns/10ps
module fskws_top
  import fskws_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC,
  parameter int HALF_CYCLES = HALF_CYC,
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int QUAL_CYCLES = QUAL_CYC
) (
  // Clock, reset, clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Demodulator and band energy levels
  input wire logic fsk_bit,
  input wire logic band_active,
  // Three-wire interface
  input wire logic serial_bit_clock_i,
  output logic serial_bit_clock_o,
  output logic serial_bit_clock_oe,
  output logic data_out,
  output logic word_ready_n_o,
  output logic word_ready_n_oe,
  output logic carrier_present_n_o,
  output logic carrier_present_n_oe
);
  typedef struct packed {
    fskws_rx_type rx;
    logic [CNT_W-1:0] bit_cnt;
    logic [IDX_W-1:0] bit_idx;
    logic [DATA_BITS-1:0] rx_sh;
    logic [CNT_W-1:0] car_cnt;
    logic car;
    logic [CNT_W-1:0] rdy_cnt;
    logic rdy;
    logic [DATA_BITS-1:0] buf_sh;
    logic [IDX_W-1:0] reads;
    logic sbc_prev;
    logic sbc;
    logic data;
    logic [DATA_BITS-1:0] last_byte;
    logic [15:0] words;
    logic mode;
    logic power_down_request;
    logic [ADDR_W-1:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic sbc_oe, rdy_n, rdy_oe, car_n, car_oe;
  } fskws_state_type;

  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] QUAL_LAST = CNT_W'(QUAL_CYCLES - 1);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DATA_BITS - 1);
  localparam logic [IDX_W-1:0] IDX_FULL = IDX_W'(DATA_BITS);

  initial begin
    if (BIT_CYCLES < 4 || BIT_CYCLES >= (1 << CNT_W))
      $error("fskws_top: BIT_CYCLES out of range");
    if (HALF_CYCLES < 1 || HALF_CYCLES >= BIT_CYCLES)
      $error("fskws_top: HALF_CYCLES out of range");
    if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << CNT_W))
      $error("fskws_top: HOLD_CYCLES out of range");
    if (QUAL_CYCLES < 1 || QUAL_CYCLES >= (1 << CNT_W))
      $error("fskws_top: QUAL_CYCLES out of range");
  end

  fskws_state_type s_q, s_d;
  logic fsk_s, band_s, sbc_s;

  // Bit clock, demodulated bit and band energy all arrive from outside
  fskws_sync #(
    .W(3)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d({fsk_bit, band_active, serial_bit_clock_i}),
    .q({fsk_s, band_s, sbc_s})
  );

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_WORDS);
  endfunction

  function automatic logic [31:0] reg_value(input logic [ADDR_W-1:0] a,
                                            input fskws_state_type s);
    logic [31:0] v;
    v = '0;
    case (a)
      REG_CTRL: begin
        v[CTRL_MODE_BIT] = s.mode;
        v[CTRL_POWER_DOWN_REQUEST_BIT] = s.power_down_request;
      end
      REG_STATUS: begin
        v[STAT_CAR_BIT] = s.car;
        v[STAT_RDY_BIT] = s.rdy;
        v[STAT_LEFT_LSB +: IDX_W] = IDX_FULL - s.reads;
        v[STAT_BYTE_LSB +: DATA_BITS] = s.last_byte;
      end
      REG_WORDS: v[15:0] = s.words;
      default: v = '0;
    endcase
    reg_value = v;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.sbc_prev = sbc_s;

    // Bus: address and data are taken in either order
    if (s_axil_awvalid && s_q.awready) begin
      s_d.awaddr = s_axil_awaddr;
      s_d.aw_held = 1'b1;
    end
    if (s_axil_wvalid && s_q.wready) begin
      s_d.wdata = s_axil_wdata;
      s_d.wstrb = s_axil_wstrb;
      s_d.w_held = 1'b1;
    end
    if (s_q.bvalid && s_axil_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.awaddr == REG_CTRL && s_q.wstrb[0]) begin
        s_d.mode = s_q.wdata[CTRL_MODE_BIT];
        s_d.power_down_request = s_q.wdata[CTRL_POWER_DOWN_REQUEST_BIT];
      end
    end
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready = !s_d.w_held && !s_d.bvalid;

    if (s_q.rvalid && s_axil_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axil_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = reg_value(s_axil_araddr, s_q);
      s_d.rresp = is_mapped(s_axil_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;

    // Carrier: qualify, then hold through dropouts
    if (!s_q.car) begin
      if (band_s) begin
        s_d.car_cnt = s_q.car_cnt + 1'b1;
        if (s_q.car_cnt == QUAL_LAST) begin
          s_d.car = 1'b1;
          s_d.car_cnt = '0;
        end
      end else begin
        s_d.car_cnt = '0;
      end
    end else begin
      if (band_s) begin
        s_d.car_cnt = '0;
      end else begin
        s_d.car_cnt = s_q.car_cnt + 1'b1;
        if (s_q.car_cnt == HOLD_LAST) begin
          s_d.car = 1'b0;
          s_d.car_cnt = '0;
        end
      end
    end

    // Word-ready lasts half a bit unless the host reads first
    if (s_q.rdy) begin
      s_d.rdy_cnt = s_q.rdy_cnt + 1'b1;
      if (s_q.rdy_cnt == HALF_LAST) begin
        s_d.rdy = 1'b0;
      end
    end

    // Host read pulses in mode 1
    if (s_q.mode && sbc_s && !s_q.sbc_prev) begin
      s_d.rdy = 1'b0;
      if (s_q.reads != IDX_FULL) begin
        s_d.data = s_q.buf_sh[0];
        s_d.buf_sh = {1'b0, s_q.buf_sh[DATA_BITS-1:1]};
        s_d.reads = s_q.reads + 1'b1;
      end
    end

    // Timing recovery, all counted in system clocks
    case (s_q.rx)
      RX_IDLE: begin
        s_d.bit_cnt = '0;
        if (!fsk_s) begin
          s_d.rx = RX_START;
        end
      end
      RX_START: begin
        s_d.bit_cnt = s_q.bit_cnt + 1'b1;
        if (s_q.bit_cnt == HALF_LAST) begin
          s_d.bit_cnt = '0;
          s_d.bit_idx = '0;
          // A start bit that is gone by mid-bit was a glitch
          s_d.rx = fsk_s ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        s_d.bit_cnt = s_q.bit_cnt + 1'b1;
        if (s_q.bit_cnt == HALF_LAST && !s_q.mode) begin
          s_d.sbc = 1'b0;
        end
        if (s_q.bit_cnt == BIT_LAST) begin
          s_d.bit_cnt = '0;
          s_d.rx_sh = {fsk_s, s_q.rx_sh[DATA_BITS-1:1]};
          s_d.bit_idx = s_q.bit_idx + 1'b1;
          if (!s_q.mode) begin
            s_d.sbc = 1'b1;
          end
          if (s_q.bit_idx == IDX_LAST) begin
            s_d.rx = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        s_d.bit_cnt = s_q.bit_cnt + 1'b1;
        if (s_q.bit_cnt == BIT_LAST) begin
          s_d.bit_cnt = '0;
          s_d.rx = RX_IDLE;
          // A missing stop bit is a framing error: the word is dropped
          if (fsk_s) begin
            s_d.rdy = 1'b1;
            s_d.rdy_cnt = '0;
            s_d.last_byte = s_q.rx_sh;
            s_d.words = s_q.words + 1'b1;
            if (s_q.mode) begin
              s_d.buf_sh = s_q.rx_sh;
              s_d.reads = '0;
            end
          end
        end
      end
      default: s_d.rx = RX_IDLE;
    endcase

    if (!s_q.mode) begin
      s_d.data = s_q.car ? fsk_s : 1'b1;
    end

    // Acting on the next carrier state ends a strobe in the same cycle
    if (!s_d.car) begin
      s_d.rx = RX_IDLE;
      s_d.sbc = 1'b1;
      if (!s_q.rdy) begin
        s_d.rdy = 1'b0;
      end
    end

    // Power-down freezes reception and leaves the pins at rest, except the data pin in mode 1, which still follows host reads
    if (s_q.power_down_request) begin
      s_d.rx = RX_IDLE;
      s_d.bit_cnt = '0;
      s_d.car = 1'b0;
      s_d.car_cnt = '0;
      s_d.rdy = 1'b0;
      s_d.sbc = 1'b1;
      if (!s_q.mode) begin
        s_d.data = 1'b1;
      end
    end
    // Pin levels are registered so no output passes through logic
    s_d.sbc_oe = !s_d.mode;
    s_d.rdy_n = !s_d.rdy;
    s_d.rdy_oe = s_d.mode | s_d.rdy;
    s_d.car_n = !s_d.car;
    s_d.car_oe = s_d.mode | s_d.car;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.rx <= RX_IDLE;
      s_q.sbc <= 1'b1;
      s_q.data <= 1'b1;
      s_q.sbc_prev <= 1'b1;
      s_q.reads <= IDX_FULL;
      s_q.mode <= CTRL_MODE_RST;
      s_q.power_down_request <= CTRL_POWER_DOWN_REQUEST_RST;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.sbc_oe <= 1'b1;
      s_q.rdy_n <= 1'b1;
      s_q.car_n <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign s_axil_awready = s_q.awready;
  assign s_axil_wready = s_q.wready;
  assign s_axil_bvalid = s_q.bvalid;
  assign s_axil_bresp = s_q.bresp;
  assign s_axil_arready = s_q.arready;
  assign s_axil_rvalid = s_q.rvalid;
  assign s_axil_rdata = s_q.rdata;
  assign s_axil_rresp = s_q.rresp;
  // Word-ready and carrier are open drain in mode 0 and drive only the low level
  assign serial_bit_clock_o = s_q.sbc;
  assign serial_bit_clock_oe = s_q.sbc_oe;
  assign data_out = s_q.data;
  assign word_ready_n_o = s_q.rdy_n;
  assign word_ready_n_oe = s_q.rdy_oe;
  assign carrier_present_n_o = s_q.car_n;
  assign carrier_present_n_oe = s_q.car_oe;
endmodule // fskws_top
